// ==== deirq_top.sv ====
// Error status registers and interrupt pin control of the display-link receiver.
`timescale 1ns/1ns
`default_nettype none
module deirq_top (
    input  wire logic                         MCLK,
    input  wire logic                         RST_B,
    input  wire logic [deirq_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [deirq_pkg::DATA_W-1:0] WDATA,
    input  wire logic                         WR,
    input  wire logic                         RD,
    output logic      [deirq_pkg::DATA_W-1:0] RDATA,
    input  wire deirq_pkg::deirq_chan_err_t   ERR_A,
    input  wire deirq_pkg::deirq_chan_err_t   ERR_B,
    input  wire logic                         PLL_LOCK,
    output logic                              IRQ_O,
    output logic                              IRQ_OE
);

    deirq_pkg::deirq_state_t st_r;
    deirq_pkg::deirq_state_t st_nxt;
    deirq_pkg::deirq_bus_req_t req;

    logic [7:0] a_set;
    logic [7:0] b_set;
    logic [7:0] a_clr;
    logic [7:0] b_clr;
    logic       pending;

    function automatic logic [7:0] latch_w1c(input logic [7:0] cur,
                                             input logic [7:0] set,
                                             input logic [7:0] clr,
                                             input logic [7:0] impl);
        // Hardware set wins over a clear in the same cycle.
        latch_w1c = ((cur & ~clr) | set) & impl;
    endfunction : latch_w1c

    always_comb begin
        req       = '0;
        req.addr  = ADDR;
        req.wdata = WDATA;
        req.wr    = WR;
        req.rd    = RD;
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.pll_lock_s1   = PLL_LOCK;
        st_nxt.pll_lock_s2   = st_r.pll_lock_s1;
        st_nxt.pll_lock_prev = st_r.pll_lock_s2;

        a_set = {ERR_A, 2'b00};
        a_set[deirq_pkg::POS_PLL_UNLOCK] = st_r.pll_lock_prev & ~st_r.pll_lock_s2;
        b_set = {ERR_B, 2'b00};
        a_clr = '0;
        b_clr = '0;

        if (req.wr) begin
            unique case (req.addr)
                deirq_pkg::OFS_GLOBAL_EN: st_nxt.global_en = req.wdata & deirq_pkg::MASK_GLOBAL;
                deirq_pkg::OFS_A_ENABLE:  st_nxt.a_enable  = req.wdata & deirq_pkg::MASK_A;
                deirq_pkg::OFS_B_ENABLE:  st_nxt.b_enable  = req.wdata & deirq_pkg::MASK_B;
                deirq_pkg::OFS_A_STATUS:  a_clr = req.wdata;
                deirq_pkg::OFS_B_STATUS:  b_clr = req.wdata;
                default: ;
            endcase
        end

        // Latching ignores the enables.
        st_nxt.a_status = latch_w1c(st_r.a_status, a_set, a_clr, deirq_pkg::MASK_A);
        st_nxt.b_status = latch_w1c(st_r.b_status, b_set, b_clr, deirq_pkg::MASK_B);

        st_nxt.rdata = '0;
        if (req.rd) begin
            unique case (req.addr)
                deirq_pkg::OFS_GLOBAL_EN: st_nxt.rdata = st_r.global_en;
                deirq_pkg::OFS_A_ENABLE:  st_nxt.rdata = st_r.a_enable;
                deirq_pkg::OFS_B_ENABLE:  st_nxt.rdata = st_r.b_enable;
                deirq_pkg::OFS_A_STATUS:  st_nxt.rdata = st_r.a_status;
                deirq_pkg::OFS_B_STATUS:  st_nxt.rdata = st_r.b_status;
                default:                  st_nxt.rdata = '0;
            endcase
        end

        pending = |(st_nxt.a_status & st_nxt.a_enable)
                | |(st_nxt.b_status & st_nxt.b_enable);
        st_nxt.irq_drive = st_nxt.global_en[deirq_pkg::POS_GLOBAL_EN] & pending;
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            st_r               <= '0;
            st_r.global_en     <= deirq_pkg::RST_GLOBAL;
            st_r.a_enable      <= deirq_pkg::RST_A_ENABLE;
            st_r.b_enable      <= deirq_pkg::RST_B_ENABLE;
            st_r.a_status      <= deirq_pkg::RST_A_STATUS;
            st_r.b_status      <= deirq_pkg::RST_B_STATUS;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign RDATA  = st_r.rdata;
    assign IRQ_O  = st_r.irq_drive;
    assign IRQ_OE = st_r.irq_drive;

endmodule : deirq_top
`default_nettype wire

// ==== deirq_pkg.sv ====
// Constants, field layouts and carrier types of the display-link error interrupt block.
package deirq_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    localparam logic [7:0] OFS_GLOBAL_EN  = 8'he0;
    localparam logic [7:0] OFS_A_ENABLE   = 8'he1;
    localparam logic [7:0] OFS_B_ENABLE   = 8'he2;
    localparam logic [7:0] OFS_A_STATUS   = 8'he5;
    localparam logic [7:0] OFS_B_STATUS   = 8'he6;

    localparam int unsigned POS_GLOBAL_EN = 0;
    localparam int unsigned POS_PLL_UNLOCK = 0;

    // Implemented bits of each register; the rest read as zero.
    localparam logic [7:0] MASK_GLOBAL = 8'h01;
    localparam logic [7:0] MASK_A      = 8'hfd;
    localparam logic [7:0] MASK_B      = 8'hfc;

    localparam logic [7:0] RST_GLOBAL   = 8'h00;
    localparam logic [7:0] RST_A_ENABLE = 8'h00;
    localparam logic [7:0] RST_B_ENABLE = 8'h00;
    localparam logic [7:0] RST_A_STATUS = 8'h01;
    localparam logic [7:0] RST_B_STATUS = 8'h00;

    // One pulse per error class, packed at the status bit positions 7..2.
    typedef struct packed {
        logic unexpected_sync;
        logic checksum_fault;
        logic uncorrectable_header;
        logic corrected_header;
        logic link_protocol_fault;
        logic leader_bit_fault;
    } deirq_chan_err_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } deirq_bus_req_t;

    typedef struct packed {
        logic [7:0] global_en;
        logic [7:0] a_enable;
        logic [7:0] b_enable;
        logic [7:0] a_status;
        logic [7:0] b_status;
        logic [7:0] rdata;
        logic       pll_lock_s1;
        logic       pll_lock_s2;
        logic       pll_lock_prev;
        logic       irq_drive;
    } deirq_state_t;

endpackage : deirq_pkg

// ==== deirq_host_pin.sv ====
// Host side view of the interrupt pin, pulled low while undriven.
`timescale 1ns/1ns
`default_nettype none
module deirq_host_pin (
    input  wire logic o,
    input  wire logic oe,
    output logic      seen
);
    assign seen = oe ? o : 1'h0;
endmodule : deirq_host_pin
`default_nettype wire

// ==== deirq_properties.sv ====
// Port checker of the error interrupt block.
`timescale 1ns/1ns
`default_nettype none
module deirq_properties (
    input wire logic                       MCLK,
    input wire logic                       RST_B,
    input wire logic [7:0]                 ADDR,
    input wire logic [7:0]                 WDATA,
    input wire logic                       WR,
    input wire logic                       RD,
    input wire logic [7:0]                 RDATA,
    input wire deirq_pkg::deirq_chan_err_t ERR_A,
    input wire deirq_pkg::deirq_chan_err_t ERR_B,
    input wire logic                       PLL_LOCK,
    input wire logic                       IRQ_O,
    input wire logic                       IRQ_OE
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    a_pin_oe_match: assert property (IRQ_OE == IRQ_O) else $error("oe");
    a_reset_quiet: assert property (disable iff (1'h0) !RST_B |=> !IRQ_OE) else $error("rst");
    a_global_off: assert property (WR && ADDR == 8'he0 && !WDATA[0] |=> !IRQ_OE) else $error("off");
    a_rise_cause: assert property ($rose(IRQ_OE) |-> $past(WR) || $past(|ERR_A) || $past(|ERR_B)
        || $past(PLL_LOCK, 4) || $past(PLL_LOCK, 5)) else $error("rise");
    a_fall_cause: assert property ($fell(IRQ_OE) |-> $past(WR)) else $error("fall");
    a_a_status_gap: assert property (RD && ADDR == 8'he5 |=> !RDATA[1]) else $error("a1");
    a_b_status_low: assert property (RD && ADDR == 8'he6 |=> RDATA[1:0] == 2'h0) else $error("b");
    a_global_bits: assert property (RD && ADDR == 8'he0 |=> RDATA[7:1] == 7'h00) else $error("g");
endmodule : deirq_properties
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench of the error interrupt block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0, lock = 1'h0, io, ioe, pin;
    logic [7:0] adr = 8'h00, wd = 8'h00, rdat;
    deirq_pkg::deirq_chan_err_t ea = '0, eb = '0;
    int error_cnt = 0, total_checks = 0;
    initial forever #10 clk = ~clk;
    deirq_top uut (.MCLK(clk), .RST_B(rst_b), .ADDR(adr), .WDATA(wd), .WR(wr), .RD(rd),
        .RDATA(rdat), .ERR_A(ea), .ERR_B(eb), .PLL_LOCK(lock), .IRQ_O(io), .IRQ_OE(ioe));
    deirq_host_pin host (.o(io), .oe(ioe), .seen(pin));
    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic wrr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask : wrr
    task automatic rdr(logic [7:0] a, logic [7:0] e);
        @(posedge clk);
        adr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        @(negedge clk);
        chk("reg", e, rdat);
    endtask : rdr
    task automatic pulse(bit b, logic [5:0] v);
        @(posedge clk);
        if (b) eb <= v;
        else ea <= v;
        @(posedge clk);
        ea <= '0;
        eb <= '0;
    endtask : pulse
    task automatic pinchk(logic e);
        @(negedge clk);
        chk("pin", {7'h00, e}, {7'h00, pin});
    endtask : pinchk
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'h1;
        rdr(8'he5, 8'h01);
        rdr(8'he6, 8'h00);
        rdr(8'he3, 8'h00);
        wrr(8'he0, 8'hff);
        rdr(8'he0, 8'h01);
        wrr(8'he1, 8'hff);
        rdr(8'he1, 8'hfd);
        pinchk(1'h1);
        wrr(8'he5, 8'h00);
        rdr(8'he5, 8'h01);
        wrr(8'he5, 8'h01);
        pinchk(1'h0);
        wrr(8'he2, 8'hff);
        rdr(8'he2, 8'hfc);
        for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < 6; i++) begin
                pulse(c[0], 6'h01 << i);
                pinchk(1'h1);
                rdr(c ? 8'he6 : 8'he5, 8'h04 << i);
                wrr(c ? 8'he6 : 8'he5, 8'hff);
                pinchk(1'h0);
            end
        end
        wrr(8'he1, 8'h00);
        pulse(1'h0, 6'h20);
        pinchk(1'h0);
        rdr(8'he5, 8'h80);
        wrr(8'he1, 8'h80);
        pinchk(1'h1);
        wrr(8'he0, 8'h00);
        pinchk(1'h0);
        wrr(8'he5, 8'hff);
        @(posedge clk) lock <= 1'h1;
        repeat (5) @(posedge clk);
        rdr(8'he5, 8'h00);
        @(posedge clk) lock <= 1'h0;
        repeat (5) @(posedge clk);
        rdr(8'he5, 8'h01);
        report_and_stop;
    end
    initial begin
        #100000;
        error_cnt++;
        report_and_stop;
    end
endmodule : tb_top
bind deirq_top deirq_properties chk_i (.MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .ERR_A(ERR_A), .ERR_B(ERR_B), .PLL_LOCK(PLL_LOCK),
    .IRQ_O(IRQ_O), .IRQ_OE(IRQ_OE));
`default_nettype wire
